// *** design/iosd_core.sv ***
// i/o register bank and decoder as seen by the processor core
// assumes the core issues at most one request per cycle and peripherals give set pulses
`timescale 1ns/10ps
`include "iosd_cfg.svh"

module iosd_core
  import iosd_pkg::*;
(
  input wire clk, // core clock
  input wire rst, // async reset, high
  input wire iosd_req_t req, // core request
  output iosd_rsp_t rsp, // answer, one cycle later
  input wire iosd_evt_t evt, // flag set pulses
  input wire iosd_pins_t pins, // sampled port pin levels
  output logic [63:0][7:0] io_regs_q, // register image for peripherals
  output logic ext_sel, // extended region strobe
  output logic ext_we, // extended region write
  output logic [7:0] ext_addr, // extended region data address
  output logic [7:0] ext_wdata, // extended region write data
  input wire [7:0] ext_rdata // extended region read data
);

  // ****************************************************************
  // register description
  // ****************************************************************
  function automatic logic [7:0] iosd_mask(input logic [5:0] idx);
    logic [7:0] m;
    m = `IOSD_MSK_NONE;
    case (idx)
      `IOSD_OFS_PTB_IN, `IOSD_OFS_PTB_DIR, `IOSD_OFS_PTB_OUT: m = `IOSD_MSK_FULL;
      `IOSD_OFS_PTC_IN, `IOSD_OFS_PTC_DIR, `IOSD_OFS_PTC_OUT: m = `IOSD_MSK_PTC;
      `IOSD_OFS_PTD_IN, `IOSD_OFS_PTD_DIR, `IOSD_OFS_PTD_OUT: m = `IOSD_MSK_FULL;
      `IOSD_OFS_T0FLG: m = `IOSD_MSK_T0FLG;
      `IOSD_OFS_T1FLG: m = `IOSD_MSK_T1FLG;
      `IOSD_OFS_T2FLG: m = `IOSD_MSK_T2FLG;
      `IOSD_OFS_PCFLG: m = `IOSD_MSK_PCFLG;
      `IOSD_OFS_EXFLG: m = `IOSD_MSK_EXFLG;
      `IOSD_OFS_EXMSK: m = `IOSD_MSK_EXMSK;
      `IOSD_OFS_T0CA: m = `IOSD_MSK_T0CA;
      `IOSD_OFS_T0CB: m = `IOSD_MSK_T0CB;
      `IOSD_OFS_T0CNT, `IOSD_OFS_T0CMPA, `IOSD_OFS_T0CMPB: m = `IOSD_MSK_FULL;
      `IOSD_OFS_GPS1, `IOSD_OFS_GPS2: m = `IOSD_MSK_FULL;
      `IOSD_OFS_SPICTL, `IOSD_OFS_SPIDAT: m = `IOSD_MSK_FULL;
      `IOSD_OFS_SPISTA: m = `IOSD_MSK_SPISTA;
      `IOSD_OFS_CMPCS: m = `IOSD_MSK_FULL;
      `IOSD_OFS_SLPCTL: m = `IOSD_MSK_SLPCTL;
      `IOSD_OFS_RSTCS: m = `IOSD_MSK_RSTCS;
      `IOSD_OFS_CORECTL: m = `IOSD_MSK_CORECTL;
      `IOSD_OFS_SPGMCTL: m = `IOSD_MSK_SPGMCTL;
      `IOSD_OFS_STKL, `IOSD_OFS_CSTAT: m = `IOSD_MSK_FULL;
      `IOSD_OFS_STKH: m = `IOSD_MSK_STKH;
      default: m = `IOSD_MSK_NONE;
    endcase
    return m;
  endfunction

  function automatic logic iosd_is_flag(input logic [5:0] idx);
    return (idx == `IOSD_OFS_T0FLG) || (idx == `IOSD_OFS_T1FLG) || (idx == `IOSD_OFS_T2FLG) ||
           (idx == `IOSD_OFS_PCFLG) || (idx == `IOSD_OFS_EXFLG);
  endfunction

  function automatic logic iosd_is_pin(input logic [5:0] idx);
    return (idx == `IOSD_OFS_PTB_IN) || (idx == `IOSD_OFS_PTC_IN) || (idx == `IOSD_OFS_PTD_IN);
  endfunction

  function automatic logic [7:0] iosd_evt_of(input logic [5:0] idx, input iosd_evt_t e);
    logic [7:0] v;
    v = 8'h00;
    case (idx)
      `IOSD_OFS_T0FLG: v = e.tmr0;
      `IOSD_OFS_T1FLG: v = e.tmr1;
      `IOSD_OFS_T2FLG: v = e.tmr2;
      `IOSD_OFS_PCFLG: v = e.pinchg;
      `IOSD_OFS_EXFLG: v = e.extirq;
      default: v = 8'h00;
    endcase
    return v;
  endfunction

  // ****************************************************************
  // request decode
  // ****************************************************************
  iosd_map_t map;

  iosd_addr_map u_map (
    .req(req),
    .map(map)
  );

  wire [7:0] tgt_mask = iosd_mask(map.idx);
  wire tgt_flag = iosd_is_flag(map.idx);
  wire tgt_pin = iosd_is_pin(map.idx);
  wire [7:0] bit_hot = 8'h01 << req.bit_sel;
  wire op_full_wr = (req.op == IOSD_OP_IO_WRITE) || (req.op == IOSD_OP_MEM_WRITE);
  wire op_bset = req.op == IOSD_OP_BIT_SET;
  wire op_bclr = req.op == IOSD_OP_BIT_CLEAR;
  wire op_skip = (req.op == IOSD_OP_SKIP_HIGH) || (req.op == IOSD_OP_SKIP_LOW);
  wire wr_any = map.hit && (op_full_wr || op_bset || op_bclr);
  // writes to an address with no implemented bit are dropped; flagged as error
  wire wr_resv = wr_any && (tgt_mask == `IOSD_MSK_NONE); // RULE10

  // pin registers show the pins, not a stored value
  wire [7:0] pin_val = (map.idx == `IOSD_OFS_PTB_IN) ? pins.port_b :
                       (map.idx == `IOSD_OFS_PTC_IN) ? pins.port_c : pins.port_d;
  wire [7:0] cur_val = (tgt_pin ? pin_val : io_regs_q[map.idx]) & tgt_mask; // RULE10
  wire [7:0] rd_val = map.ext_hit ? ext_rdata : (map.hit ? cur_val : 8'h00);
  wire skip_bit = cur_val[req.bit_sel]; // RULE4
  wire skip_res = (req.op == IOSD_OP_SKIP_HIGH) ? skip_bit : !skip_bit; // RULE4

  // a flag register takes a written one as a clear; a bit op writes only its own bit
  wire [7:0] flag_clr = op_full_wr ? req.wdata : (op_bset ? bit_hot : 8'h00); // RULE5 RULE6
  wire [7:0] plain_new = op_full_wr ? req.wdata :
                         op_bset ? (io_regs_q[map.idx] | bit_hot) :
                         (io_regs_q[map.idx] & ~bit_hot); // RULE3 RULE6

  // ****************************************************************
  // register next state
  // ****************************************************************
  logic [63:0][7:0] io_regs_d;

  always_comb begin
    logic [7:0] m;
    logic [7:0] setv;
    logic [7:0] clr;
    m = 8'h00;
    setv = 8'h00;
    clr = 8'h00;
    for (int i = 0; i < 64; i++) begin
      m = iosd_mask(6'(i));
      setv = iosd_evt_of(6'(i), evt);
      clr = (wr_any && (map.idx == 6'(i))) ? flag_clr : 8'h00;
      if (iosd_is_pin(6'(i))) begin
        io_regs_d[i] = `IOSD_RST_VAL;
      end else if (iosd_is_flag(6'(i))) begin
        // set beats clear when both land in one cycle
        io_regs_d[i] = ((io_regs_q[i] & ~clr) | setv) & m; // RULE5
      end else if (wr_any && (map.idx == 6'(i))) begin
        io_regs_d[i] = plain_new & m; // RULE10
      end else begin
        io_regs_d[i] = io_regs_q[i] & m;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      io_regs_q <= '0;
    end else begin
      io_regs_q <= io_regs_d;
    end
  end

  // ****************************************************************
  // extended region strobe
  // ****************************************************************
  // passed straight through so the extended answer lands in the same cycle as local reads
  assign ext_sel = map.ext_hit; // RULE9
  assign ext_we = map.ext_hit && (req.op == IOSD_OP_MEM_WRITE);
  assign ext_addr = map.ext_hit ? req.addr : 8'h00;
  assign ext_wdata = map.ext_hit ? req.wdata : 8'h00;

  // ****************************************************************
  // answer to the core
  // ****************************************************************
  // a net, so each field may have its own continuous assignment
  wire iosd_rsp_t rsp_d;

  assign rsp_d.valid = req.valid;
  assign rsp_d.rdata = (op_full_wr || op_bset || op_bclr || op_skip) ? 8'h00 : rd_val;
  assign rsp_d.skip = map.hit && op_skip && skip_res; // RULE4
  assign rsp_d.err = map.bad || wr_resv; // RULE3 RULE7 RULE9

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rsp <= '0;
    end else begin
      rsp <= rsp_d;
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  wire past_bitop_high = req.valid && (op_bset || op_bclr || op_skip) && (req.addr > `IOSD_BIT_LAST);
  wire past_io_high = req.valid && ((req.op == IOSD_OP_IO_READ) || (req.op == IOSD_OP_IO_WRITE)) &&
                      (req.addr > `IOSD_IO_LAST);
  wire bit_wr_ok = map.hit && (op_bset || op_bclr);
  wire skip_ok = map.hit && op_skip;
  wire flag_wr = map.hit && op_full_wr && tgt_flag;
  wire gps1_ds_wr = req.valid && (req.op == IOSD_OP_MEM_WRITE) &&
                    (req.addr == ({2'b00, `IOSD_OFS_GPS1} + `IOSD_DS_OFFSET));
  wire resv_io_rd = map.hit && (req.op == IOSD_OP_IO_READ) && (tgt_mask == `IOSD_MSK_NONE);
  wire [7:0] cur_setv = iosd_evt_of(map.idx, evt);
  wire flag_bclr = map.hit && op_bclr && tgt_flag;
  wire pin_wr = map.hit && op_full_wr && tgt_pin;

  // a refused bit op must leave its register alone; only peripheral set pulses may land
  property p_bit_range;
    logic [5:0] k;
    logic [7:0] old;
    @(posedge clk) disable iff (rst)
      (past_bitop_high, k = map.idx, old = (io_regs_q[map.idx] | cur_setv) & tgt_mask) |=>
        rsp.err && !rsp.skip && (io_regs_q[k] == old);
  endproperty
  a_bit_range: assert property (p_bit_range) else $error("bit op above low range not refused"); // RULE3

  property p_skip;
    @(posedge clk) disable iff (rst)
      skip_ok |=> rsp.valid && (rsp.skip == ($past(skip_bit) == ($past(req.op) == IOSD_OP_SKIP_HIGH)));
  endproperty
  a_skip: assert property (p_skip) else $error("skip answer does not follow tested bit"); // RULE4

  property p_w1c;
    logic [5:0] k;
    logic [7:0] v;
    @(posedge clk) disable iff (rst)
      (flag_wr, k = map.idx, v = ((io_regs_q[map.idx] & ~req.wdata) | cur_setv) & tgt_mask) |=>
        io_regs_q[k] == v;
  endproperty
  a_w1c: assert property (p_w1c) else $error("flag register write is not write-one-to-clear"); // RULE5

  property p_bit_only;
    logic [5:0] k;
    logic [7:0] keep;
    logic [7:0] old;
    @(posedge clk) disable iff (rst)
      (bit_wr_ok && !tgt_pin, k = map.idx, keep = ~bit_hot & ~cur_setv, old = io_regs_q[map.idx]) |=>
        ((io_regs_q[k] ^ old) & keep) == 8'h00;
  endproperty
  a_bit_only: assert property (p_bit_only) else $error("bit op disturbed other bits"); // RULE6

  property p_io_range;
    @(posedge clk) disable iff (rst)
      past_io_high |-> !ext_sel ##1 rsp.err && (rsp.rdata == 8'h00);
  endproperty
  a_io_range: assert property (p_io_range) else $error("port read beyond i/o range not refused"); // RULE7

  property p_ds_offset;
    logic [7:0] v;
    @(posedge clk) disable iff (rst)
      (gps1_ds_wr, v = req.wdata) |=> (io_regs_q[`IOSD_OFS_GPS1] == v) && !rsp.err;
  endproperty
  a_ds_offset: assert property (p_ds_offset) else $error("data-space store missed offset register"); // RULE8

  property p_ext_only;
    @(posedge clk) disable iff (rst)
      ext_sel |-> (req.op inside {IOSD_OP_MEM_READ, IOSD_OP_MEM_WRITE}) && (req.addr >= `IOSD_EXT_FIRST)
        ##1 !rsp.err;
  endproperty
  a_ext_only: assert property (p_ext_only) else $error("extended region reached by wrong access"); // RULE9

  property p_resv_zero;
    @(posedge clk) disable iff (rst)
      resv_io_rd |=> rsp.valid && (rsp.rdata == 8'h00) && !rsp.err;
  endproperty
  a_resv_zero: assert property (p_resv_zero) else $error("reserved address read not zero"); // RULE10

  property p_one_answer;
    @(posedge clk) disable iff (rst)
      rsp.valid == $past(req.valid);
  endproperty
  a_one_answer: assert property (p_one_answer) else $error("answer not one cycle after request"); // RULE7

  // a bit clear on a flag register must never clear a flag
  property p_bclr_flag;
    logic [5:0] k;
    logic [7:0] old;
    @(posedge clk) disable iff (rst)
      (flag_bclr, k = map.idx, old = io_regs_q[map.idx]) |=>
        ((io_regs_q[k] & old) == old) && !rsp.err;
  endproperty
  a_bclr_flag: assert property (p_bclr_flag) else $error("bit clear disturbed a status flag"); // RULE6

  property p_pin_keep;
    logic [5:0] k;
    @(posedge clk) disable iff (rst)
      (pin_wr, k = map.idx) |=> !rsp.err && (io_regs_q[k] == 8'h00);
  endproperty
  a_pin_keep: assert property (p_pin_keep) else $error("pin register took a written value"); // RULE10

  property p_ext_quiet;
    @(posedge clk) disable iff (rst)
      !ext_sel |-> !ext_we && (ext_addr == 8'h00) && (ext_wdata == 8'h00);
  endproperty
  a_ext_quiet: assert property (p_ext_quiet) else $error("extended port active while unselected"); // RULE9

endmodule

// *** design/iosd_cfg.svh ***
// constants of the i/o space access decoder: offsets, field masks, reset values
// assumes inclusion by every design file that decodes addresses
//
// Function
// RULE1 - software writes zero into every reserved bit it touches
// RULE2 - software never writes an i/o address that is reserved
// RULE3 - bit set and bit clear act on i/o addresses 0x00 to 0x1f only
// RULE4 - skip tests sample one chosen bit of a low i/o register
// RULE5 - status flags clear on a written one; a written zero leaves them
// RULE6 - bit set or clear changes only the addressed bit, never sibling flags
// RULE7 - port read and write instructions use i/o addresses 0x00 to 0x3f
// RULE8 - data-space loads and stores see each i/o register at address plus 0x20
// RULE9 - extended region 0x60 to 0xff is reached by data-space access only
// RULE10 - reserved bits and addresses read zero; writes to them do nothing
`ifndef IOSD_CFG_SVH
`define IOSD_CFG_SVH

// ****************************************************************
// address ranges
// ****************************************************************
`define IOSD_IO_LAST 8'h3f
`define IOSD_BIT_LAST 8'h1f
`define IOSD_DS_OFFSET 8'h20
`define IOSD_DS_IO_LAST 8'h5f
`define IOSD_EXT_FIRST 8'h60
`define IOSD_EXT_LAST 8'hff

// ****************************************************************
// register offsets in i/o addressing
// ****************************************************************
`define IOSD_OFS_PTB_IN 6'h03
`define IOSD_OFS_PTB_DIR 6'h04
`define IOSD_OFS_PTB_OUT 6'h05
`define IOSD_OFS_PTC_IN 6'h06
`define IOSD_OFS_PTC_DIR 6'h07
`define IOSD_OFS_PTC_OUT 6'h08
`define IOSD_OFS_PTD_IN 6'h09
`define IOSD_OFS_PTD_DIR 6'h0a
`define IOSD_OFS_PTD_OUT 6'h0b
`define IOSD_OFS_T0FLG 6'h15
`define IOSD_OFS_T1FLG 6'h16
`define IOSD_OFS_T2FLG 6'h17
`define IOSD_OFS_PCFLG 6'h1b
`define IOSD_OFS_EXFLG 6'h1c
`define IOSD_OFS_EXMSK 6'h1d
`define IOSD_OFS_T0CA 6'h24
`define IOSD_OFS_T0CB 6'h25
`define IOSD_OFS_T0CNT 6'h26
`define IOSD_OFS_T0CMPA 6'h27
`define IOSD_OFS_T0CMPB 6'h28
`define IOSD_OFS_GPS1 6'h2a
`define IOSD_OFS_GPS2 6'h2b
`define IOSD_OFS_SPICTL 6'h2c
`define IOSD_OFS_SPISTA 6'h2d
`define IOSD_OFS_SPIDAT 6'h2e
`define IOSD_OFS_CMPCS 6'h30
`define IOSD_OFS_SLPCTL 6'h33
`define IOSD_OFS_RSTCS 6'h34
`define IOSD_OFS_CORECTL 6'h35
`define IOSD_OFS_SPGMCTL 6'h37
`define IOSD_OFS_STKL 6'h3d
`define IOSD_OFS_STKH 6'h3e
`define IOSD_OFS_CSTAT 6'h3f

// ****************************************************************
// implemented-bit masks
// ****************************************************************
`define IOSD_MSK_FULL 8'hff
`define IOSD_MSK_PTC 8'h7f
`define IOSD_MSK_T0FLG 8'h07
`define IOSD_MSK_T1FLG 8'h27
`define IOSD_MSK_T2FLG 8'h07
`define IOSD_MSK_PCFLG 8'h07
`define IOSD_MSK_EXFLG 8'h03
`define IOSD_MSK_EXMSK 8'h03
`define IOSD_MSK_T0CA 8'hf3
`define IOSD_MSK_T0CB 8'hcf
`define IOSD_MSK_SPISTA 8'hc1
`define IOSD_MSK_SLPCTL 8'h0f
`define IOSD_MSK_RSTCS 8'h0f
`define IOSD_MSK_CORECTL 8'h73
`define IOSD_MSK_SPGMCTL 8'hdf
`define IOSD_MSK_STKH 8'h07
`define IOSD_MSK_NONE 8'h00

`define IOSD_RST_VAL 8'h00

`endif

// *** design/iosd_pkg.sv ***
// types shared by the i/o space access decoder and its address map
// assumes the constants header sits beside it on the include path
package iosd_pkg;

  // ****************************************************************
  // core operations
  // ****************************************************************
  typedef enum logic [2:0] {
    IOSD_OP_IO_READ = 3'h0,
    IOSD_OP_IO_WRITE = 3'h1,
    IOSD_OP_BIT_SET = 3'h3,
    IOSD_OP_BIT_CLEAR = 3'h2,
    IOSD_OP_SKIP_HIGH = 3'h6,
    IOSD_OP_SKIP_LOW = 3'h7,
    IOSD_OP_MEM_READ = 3'h5,
    IOSD_OP_MEM_WRITE = 3'h4
  } iosd_op_t;

  typedef struct packed {
    logic valid;
    iosd_op_t op;
    logic [7:0] addr;
    logic [2:0] bit_sel;
    logic [7:0] wdata;
  } iosd_req_t;

  typedef struct packed {
    logic valid;
    logic [7:0] rdata;
    logic skip;
    logic err;
  } iosd_rsp_t;

  // one-cycle set pulses from the peripherals, per flag bit
  typedef struct packed {
    logic [7:0] tmr0;
    logic [7:0] tmr1;
    logic [7:0] tmr2;
    logic [7:0] pinchg;
    logic [7:0] extirq;
  } iosd_evt_t;

  typedef struct packed {
    logic [7:0] port_b;
    logic [7:0] port_c;
    logic [7:0] port_d;
  } iosd_pins_t;

  typedef struct packed {
    logic hit;
    logic [5:0] idx;
    logic ext_hit;
    logic bad;
  } iosd_map_t;

endpackage

// *** design/iosd_addr_map.sv ***
// address map of one core request: i/o index, extended region hit, range errors
// assumes a request structure held stable for the cycle it is valid
`timescale 1ns/10ps
`include "iosd_cfg.svh"

module iosd_addr_map
  import iosd_pkg::*;
(
  input wire iosd_req_t req, // request from the core
  output wire iosd_map_t map // decoded target
);

  wire is_io_op = (req.op == IOSD_OP_IO_READ) || (req.op == IOSD_OP_IO_WRITE);
  wire is_bit_op = (req.op == IOSD_OP_BIT_SET) || (req.op == IOSD_OP_BIT_CLEAR) ||
                   (req.op == IOSD_OP_SKIP_HIGH) || (req.op == IOSD_OP_SKIP_LOW);
  wire is_mem_op = (req.op == IOSD_OP_MEM_READ) || (req.op == IOSD_OP_MEM_WRITE);
  wire io_ok = req.addr <= `IOSD_IO_LAST; // RULE7
  wire bit_ok = req.addr <= `IOSD_BIT_LAST; // RULE3
  wire ds_io = (req.addr >= `IOSD_DS_OFFSET) && (req.addr <= `IOSD_DS_IO_LAST);
  wire ds_ext = req.addr >= `IOSD_EXT_FIRST;
  wire [7:0] ds_idx = req.addr - `IOSD_DS_OFFSET; // RULE8

  // below the data-space offset sit the core's working registers, not ours
  assign map.hit = req.valid && ((is_io_op && io_ok) || (is_bit_op && bit_ok) || (is_mem_op && ds_io));
  assign map.idx = is_mem_op ? ds_idx[5:0] : req.addr[5:0];
  assign map.ext_hit = req.valid && is_mem_op && ds_ext; // RULE9
  assign map.bad = req.valid && !map.hit && !map.ext_hit;

endmodule

// *** sim/iosd_ext_mem.sv ***
// far-side model of the extended i/o region behind the ext port
// assumes the decoder drives ext_* combinationally and wants read data in the same cycle
`timescale 1ns/10ps

module iosd_ext_mem (
  input wire clk, // core clock
  input wire ext_sel, // region selected
  input wire ext_we, // store
  input wire [7:0] ext_addr, // data address
  input wire [7:0] ext_wdata, // store data
  output logic [7:0] ext_rdata // load data
);
  // ****************************************************************
  // storage
  // ****************************************************************
  logic [7:0] mem [256];
  logic [7:0] last_q = 8'h00;

  always @(posedge clk) begin
    if (ext_sel && ext_we) begin
      mem[ext_addr] <= ext_wdata;
    end
    if (ext_sel) begin
      last_q <= ext_rdata;
    end
  end

  // unselected: show the inverse of the last value so a stale read never matches
  assign ext_rdata = ext_sel ? mem[ext_addr] : ~last_q;
endmodule

// *** sim/tb_top.sv ***
// self-checking bench of the i/o space decoder: core requests, flag events, pins
// assumes the decoder answers every request exactly one cycle later
`timescale 1ns/10ps
`include "iosd_cfg.svh"

module tb_top;
  import iosd_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  iosd_req_t req = '0;
  iosd_rsp_t rsp;
  iosd_evt_t evt = '0;
  iosd_pins_t pins = '0;
  logic [63:0][7:0] io_regs_q;
  logic ext_sel, ext_we;
  logic [7:0] ext_addr, ext_wdata, ext_rdata;
  logic [7:0] m [64];
  logic [7:0] xm [256];
  logic [7:0] fl [5] = '{8'h15, 8'h16, 8'h17, 8'h1b, 8'h1c};
  logic [7:0] ea [3] = '{8'h60, 8'h80, 8'hff};
  iosd_rsp_t notes [$];
  int err_count = 0;
  int checked = 0;
  int cyc = 0;

  always #4 clk = ~clk;

  iosd_core dut (.clk(clk), .rst(rst), .req(req), .rsp(rsp), .evt(evt), .pins(pins),
    .io_regs_q(io_regs_q), .ext_sel(ext_sel), .ext_we(ext_we), .ext_addr(ext_addr),
    .ext_wdata(ext_wdata), .ext_rdata(ext_rdata));
  iosd_ext_mem ext (.clk(clk), .ext_sel(ext_sel), .ext_we(ext_we), .ext_addr(ext_addr),
    .ext_wdata(ext_wdata), .ext_rdata(ext_rdata));

  // ****************************************************************
  // expected register model
  // ****************************************************************
  function automatic logic [7:0] msk(input logic [5:0] i);
    case (i)
      6'h03, 6'h04, 6'h05, 6'h09, 6'h0a, 6'h0b, 6'h26, 6'h27, 6'h28, 6'h2a, 6'h2b, 6'h2c, 6'h2e, 6'h30, 6'h3d,
      6'h3f: msk = `IOSD_MSK_FULL;
      6'h06, 6'h07, 6'h08: msk = `IOSD_MSK_PTC;
      6'h15, 6'h17, 6'h1b: msk = 8'h07;
      6'h16: msk = `IOSD_MSK_T1FLG;
      6'h1c, 6'h1d: msk = 8'h03;
      6'h24: msk = `IOSD_MSK_T0CA;
      6'h25: msk = `IOSD_MSK_T0CB;
      6'h2d: msk = `IOSD_MSK_SPISTA;
      6'h33, 6'h34: msk = 8'h0f;
      6'h35: msk = `IOSD_MSK_CORECTL;
      6'h37: msk = `IOSD_MSK_SPGMCTL;
      6'h3e: msk = `IOSD_MSK_STKH;
      default: msk = `IOSD_MSK_NONE;
    endcase
  endfunction

  task automatic cmp_rsp(input iosd_rsp_t g, input iosd_rsp_t e);
    checked++;
    if (g !== e) begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic cmp8(input logic [7:0] g, input logic [7:0] e);
    checked++;
    if (g !== e) begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic final_report();
    $display("comparisons %0d, mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // ****************************************************************
  // drivers
  // ****************************************************************
  task automatic issue(input iosd_op_t op, input logic [7:0] a, input logic [2:0] b, input logic [7:0] w);
    iosd_rsp_t e;
    logic [5:0] i;
    logic [7:0] v;
    logic mo, pin, fg, bad;
    e = '0;
    e.valid = 1'b1;
    mo = op inside {IOSD_OP_MEM_READ, IOSD_OP_MEM_WRITE};
    i = mo ? 6'(a - `IOSD_DS_OFFSET) : a[5:0];
    pin = i inside {6'h03, 6'h06, 6'h09};
    fg = i inside {6'h15, 6'h16, 6'h17, 6'h1b, 6'h1c};
    v = pin ? (i == 6'h03 ? pins.port_b : i == 6'h06 ? pins.port_c & 8'h7f : pins.port_d) : m[i];
    if (op inside {IOSD_OP_IO_READ, IOSD_OP_IO_WRITE}) bad = a > `IOSD_IO_LAST;
    else if (mo) bad = a < `IOSD_DS_OFFSET;
    else bad = a > `IOSD_BIT_LAST;
    if (!bad && !(mo && a >= `IOSD_EXT_FIRST) && msk(i) == 8'h00 &&
        !(op inside {IOSD_OP_IO_READ, IOSD_OP_MEM_READ, IOSD_OP_SKIP_HIGH, IOSD_OP_SKIP_LOW})) bad = 1'b1;
    e.err = bad;
    if (!bad && mo && a >= `IOSD_EXT_FIRST) begin
      if (op == IOSD_OP_MEM_WRITE) xm[a] = w;
      else e.rdata = xm[a];
    end else if (!bad) begin
      case (op)
        IOSD_OP_IO_READ, IOSD_OP_MEM_READ: e.rdata = v;
        IOSD_OP_SKIP_HIGH: e.skip = v[b];
        IOSD_OP_SKIP_LOW: e.skip = !v[b];
        IOSD_OP_IO_WRITE, IOSD_OP_MEM_WRITE: if (fg) m[i] &= ~w; else if (!pin) m[i] = w & msk(i);
        IOSD_OP_BIT_SET: if (fg) m[i] &= ~(8'h01 << b); else if (!pin) m[i] |= (8'h01 << b) & msk(i);
        default: if (!fg && !pin) m[i] &= ~(8'h01 << b);
      endcase
    end
    @(posedge clk);
    #1;
    req = '{1'b1, op, a, b, w};
    evt = '0;
    notes.push_back(e);
  endtask

  task automatic idle(input string name);
    @(posedge clk);
    #1;
    req.valid = 1'b0;
    evt = '0;
    repeat (3) @(posedge clk);
    $display("test %s done", name);
  endtask

  task automatic pulse(input iosd_evt_t v);
    @(posedge clk);
    #1;
    req.valid = 1'b0;
    evt = v;
    m[8'h15] |= v.tmr0 & msk(6'h15);
    m[8'h16] |= v.tmr1 & msk(6'h16);
    m[8'h17] |= v.tmr2 & msk(6'h17);
    m[8'h1b] |= v.pinchg & msk(6'h1b);
    m[8'h1c] |= v.extirq & msk(6'h1c);
  endtask

  // ****************************************************************
  // answer monitor and hang guard
  // ****************************************************************
  always @(negedge clk) begin
    cyc++;
    if (cyc > 4000) begin
      err_count++;
      final_report();
    end else if (!rst && rsp.valid === 1'b1) begin
      if (notes.size() == 0) cmp_rsp(rsp, '0);
      else cmp_rsp(rsp, notes.pop_front());
    end
  end

  initial begin
    logic [7:0] a;
    logic [2:0] b;
    void'($urandom(32'hb67ce42b));
    pins = 24'($urandom);
    for (int k = 0; k < 64; k++) m[k] = `IOSD_RST_VAL;
    repeat (5) @(posedge clk);
    #1;
    rst = 1'b0;
    for (int k = 0; k < 64; k++) issue(IOSD_OP_IO_READ, 8'(k), 3'h0, 8'h00);
    idle("reset values");
    for (int k = 0; k < 64; k++) begin
      if (msk(6'(k)) != 8'h00) begin
        issue(IOSD_OP_IO_WRITE, 8'(k), 3'h0, 8'($urandom) & msk(6'(k)));
        issue(IOSD_OP_MEM_READ, 8'(k + 32), 3'h0, 8'h00);
      end
    end
    issue(IOSD_OP_MEM_WRITE, 8'h28, 3'h0, 8'hff);
    issue(IOSD_OP_MEM_WRITE, 8'h4a, 3'h0, 8'($urandom));
    issue(IOSD_OP_IO_READ, 8'h2a, 3'h0, 8'h00);
    issue(IOSD_OP_IO_READ, 8'h08, 3'h0, 8'h00);
    issue(IOSD_OP_IO_WRITE, 8'h0c, 3'h0, 8'h5a);
    issue(IOSD_OP_IO_READ, 8'h0c, 3'h0, 8'h00);
    idle("write and data-space read");
    for (int k = 0; k < 32; k++) begin
      a = 8'(k);
      b = 3'($urandom);
      if (msk(a[5:0]) != 8'h00 && !(k inside {3, 6, 9})) begin
        issue(IOSD_OP_BIT_SET, a, b, 8'h00);
        issue(IOSD_OP_SKIP_HIGH, a, b, 8'h00);
        issue(IOSD_OP_BIT_CLEAR, a, b + 3'h1, 8'h00);
        issue(IOSD_OP_SKIP_LOW, a, b + 3'h1, 8'h00);
        issue(IOSD_OP_IO_READ, a, 3'h0, 8'h00);
      end
    end
    issue(IOSD_OP_SKIP_HIGH, 8'h03, 3'h5, 8'h00);
    issue(IOSD_OP_SKIP_LOW, 8'h09, 3'h2, 8'h00);
    idle("bit operations");
    for (int r = 0; r < 2; r++) begin
      pulse(40'({$urandom, $urandom}));
      for (int k = 0; k < 5; k++) begin
        b = 3'($urandom);
        issue(IOSD_OP_MEM_READ, fl[k] + 8'h20, 3'h0, 8'h00);
        issue(IOSD_OP_BIT_CLEAR, fl[k], b, 8'h00);
        issue(IOSD_OP_BIT_SET, fl[k], b, 8'h00);
        issue(IOSD_OP_IO_READ, fl[k], 3'h0, 8'h00);
        issue(r == 0 ? IOSD_OP_IO_WRITE : IOSD_OP_MEM_WRITE, fl[k] + 8'(r * 32), 3'h0,
          8'($urandom) & msk(fl[k][5:0]));
        issue(IOSD_OP_IO_READ, fl[k], 3'h0, 8'h00);
      end
    end
    idle("status flags");
    issue(IOSD_OP_IO_READ, 8'h40, 3'h0, 8'h00);
    issue(IOSD_OP_IO_WRITE, 8'h60, 3'h0, 8'h11);
    issue(IOSD_OP_BIT_SET, 8'h20, 3'h0, 8'h00);
    issue(IOSD_OP_SKIP_LOW, 8'h3f, 3'h0, 8'h00);
    issue(IOSD_OP_MEM_READ, 8'h1f, 3'h0, 8'h00);
    for (int k = 0; k < 3; k++) issue(IOSD_OP_MEM_WRITE, ea[k], 3'h0, 8'($urandom));
    for (int k = 0; k < 3; k++) issue(IOSD_OP_MEM_READ, ea[k], 3'h0, 8'h00);
    idle("range refusals and extended region");
    for (int k = 0; k < 64; k++) begin
      cmp8(io_regs_q[k], (k inside {3, 6, 9}) ? 8'h00 : m[k]);
    end
    cmp8(8'(notes.size()), 8'h00);
    $display("test register image done");
    final_report();
  end
endmodule
